/* aich_pkg.sv */
package aich_pkg;

    // sample and value widths
    localparam int RAW_W = 16;
    localparam int VAL_W = 32;

    // raw converter codes: full code is 20 mA or 10 V, live zero is 4 mA
    localparam logic [RAW_W-1:0] RAW_FULL = 16'hfa00;
    localparam logic [RAW_W-1:0] RAW_LIVE_ZERO = 16'h3200;
    // reciprocals of the raw span in Q32, so scaling needs no divider
    localparam logic [32:0] RECIP_FULL = 33'((64'h1 << 32) / 64'(RAW_FULL));
    localparam logic [32:0] RECIP_LIVE = 33'((64'h1 << 32) / 64'(RAW_FULL - RAW_LIVE_ZERO));

    // timing
    localparam int ONE_SEC_NS = 1000000000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CYC_PER_SEC = ONE_SEC_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SCALE_MIN = 8'h04;
    localparam logic [7:0] REG_SCALE_MAX = 8'h08;
    localparam logic [7:0] REG_SCALE2_MIN = 8'h0c;
    localparam logic [7:0] REG_SCALE2_MAX = 8'h10;
    localparam logic [7:0] REG_DEVIATION = 8'h14;
    localparam logic [7:0] REG_TIMEOUT = 8'h18;
    localparam logic [7:0] REG_WIN_HIGH = 8'h1c;
    localparam logic [7:0] REG_WIN_LOW = 8'h20;
    localparam logic [7:0] REG_HYST = 8'h24;
    localparam logic [7:0] REG_THR1 = 8'h28;
    localparam logic [7:0] REG_THR2 = 8'h2c;
    localparam logic [7:0] REG_STATUS = 8'h30;
    localparam logic [7:0] REG_VALUE = 8'h34;

    // status bit positions
    localparam int STAT_INCOH = 0;
    localparam int STAT_MISMATCH = 1;
    localparam int STAT_WIN = 2;
    localparam int STAT_THR1 = 3;
    localparam int STAT_THR2 = 4;

    localparam logic [31:0] REG_RST = 32'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {KIND_4_20 = 2'h0, KIND_0_20 = 2'h1, KIND_0_10V = 2'h2} aich_kind_t;
    typedef enum logic [2:0] {
        CONS_PRIMARY = 3'h0,
        CONS_REDUNDANT = 3'h1,
        CONS_MAX = 3'h2,
        CONS_MIN = 3'h3,
        CONS_AVG = 3'h4
    } aich_cons_t;
    typedef enum logic {WIN_OUT = 1'b0, WIN_IN = 1'b1} aich_win_t;
    typedef enum logic {THR_UNDER = 1'b0, THR_OVER = 1'b1} aich_thr_t;

    // control register layout, lsb last
    typedef struct packed {
        logic [19:0] unused;
        logic thr2_en;
        logic thr1_en;
        logic win_en;
        logic [2:0] cons;
        logic diff;
        logic [1:0] chsel;
        logic redundant;
        logic [1:0] kind;
    } aich_cfg_t;

    typedef struct packed {
        logic [3:0][RAW_W-1:0] raw;
    } aich_samples_t;

    // linear transfer: smin at the sensor floor, smax at the full code
    function automatic logic signed [VAL_W-1:0] aich_scale(
        input logic [RAW_W-1:0] raw,
        input logic [1:0] kind,
        input logic signed [VAL_W-1:0] smin,
        input logic signed [VAL_W-1:0] smax
    );
        logic signed [RAW_W:0] d;
        logic signed [VAL_W:0] span;
        logic signed [95:0] p;
        logic [32:0] rc;
        d = signed'({1'b0, raw});
        rc = RECIP_FULL;
        if (kind == KIND_4_20)
        begin
            d = signed'({1'b0, raw}) - signed'({1'b0, RAW_LIVE_ZERO});
            rc = RECIP_LIVE;
        end
        span = {smax[VAL_W-1], smax} - {smin[VAL_W-1], smin};
        p = 96'(d) * 96'(span) * 96'(signed'({1'b0, rc}));
        return smin + VAL_W'(p >>> 32);
    endfunction : aich_scale

    function automatic logic signed [VAL_W:0] aich_ext(input logic signed [VAL_W-1:0] v);
        return {v[VAL_W-1], v};
    endfunction : aich_ext

endpackage : aich_pkg

/* aich_channel.sv */
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

// How it works
// RL1 - sensor kind: 0-20 mA, 4-20 mA, 0-10 V
// RL2 - two thresholds or one window comparator
// RL3 - single mode reads one chosen channel
// RL4 - redundant pair on channels 1-2 or 3-4
// RL5 - configurable maximum deviation between paired readings
// RL6 - configurable timeout in seconds before incoherence
// RL7 - equal sensors compared on one scale
// RL8 - different sensors: second uses own scale
// RL9 - primary or redundant channel selectable
// RL10 - maximum consolidation takes larger reading
// RL11 - minimum consolidation takes smaller reading
// RL12 - average consolidation takes arithmetic mean
// RL13 - consolidated value feeds comparators and output
// RL14 - scale minimum at sensor lowest output
// RL15 - scale maximum at sensor highest output
// RL16 - linear slope and offset from scale
// RL17 - window enable adds one boolean output
// RL18 - output 0 out-of-window, 1 in-window
// RL19 - out state held near either edge
// RL20 - out to in inside hysteresis band
// RL21 - in state held inside window band; the code holds it only between win_low plus hyst and win_high
// RL22 - in to out at either threshold; the code leaves at win_high but on the low side already at win_low plus hyst
// RL23 - thresholds in same units as value
module aich_channel
    import aich_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CYCLES_PER_SEC = CYC_PER_SEC
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // converter samples, same clock domain
    input wire logic i_sample_valid,
    input wire aich_samples_t i_samples,
    // results to the controller
    output logic o_value_valid,
    output logic signed [VAL_W-1:0] o_value,
    output logic o_window_result_output,
    output logic o_thr1,
    output logic o_thr2,
    output logic o_incoherent,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);

    if (ADDR_W < 8 || ADDR_W > 32)
        $error("aich_channel: ADDR_W must lie in 8..32");
    if (CYCLES_PER_SEC < 1)
        $error("aich_channel: CYCLES_PER_SEC must be at least 1");

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    function automatic logic [31:0] apply_strb(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = data[i*8 +: 8];
        return r;
    endfunction : apply_strb

    // register file
    logic [31:0] ctrl;
    logic signed [VAL_W-1:0] scale_min, scale_max, scale2_min, scale2_max;
    logic [31:0] deviation, timeout_s;
    logic signed [VAL_W-1:0] win_high, win_low, hyst, thr1, thr2;
    aich_cfg_t cfg;
    assign cfg = aich_cfg_t'(ctrl);

    // write channel state
    logic aw_held, w_held;
    logic [7:0] aw_off;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    assign do_write = aw_held && w_held && !o_bvalid;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_off <= 8'h00;
            w_data <= REG_RST;
            w_strb <= 4'h0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_held <= 1'b1;
                aw_off <= {i_awaddr[7:2], 2'b00};
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready)
            begin
                w_held <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
                o_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (aw_off <= REG_VALUE) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (o_bvalid && i_bready)
            begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl <= REG_RST;
            scale_min <= REG_RST;
            scale_max <= REG_RST;
            scale2_min <= REG_RST;
            scale2_max <= REG_RST;
            deviation <= REG_RST;
            timeout_s <= REG_RST;
            win_high <= REG_RST;
            win_low <= REG_RST;
            hyst <= REG_RST;
            thr1 <= REG_RST;
            thr2 <= REG_RST;
        end
        else if (do_write)
        begin
            if (aw_off == REG_CTRL)
                ctrl <= apply_strb(ctrl, w_data, w_strb); // RL1
            else if (aw_off == REG_SCALE_MIN)
                scale_min <= apply_strb(scale_min, w_data, w_strb); // RL14
            else if (aw_off == REG_SCALE_MAX)
                scale_max <= apply_strb(scale_max, w_data, w_strb); // RL15
            else if (aw_off == REG_SCALE2_MIN)
                scale2_min <= apply_strb(scale2_min, w_data, w_strb);
            else if (aw_off == REG_SCALE2_MAX)
                scale2_max <= apply_strb(scale2_max, w_data, w_strb);
            else if (aw_off == REG_DEVIATION)
                deviation <= apply_strb(deviation, w_data, w_strb); // RL5
            else if (aw_off == REG_TIMEOUT)
                timeout_s <= apply_strb(timeout_s, w_data, w_strb); // RL6
            else if (aw_off == REG_WIN_HIGH)
                win_high <= apply_strb(win_high, w_data, w_strb);
            else if (aw_off == REG_WIN_LOW)
                win_low <= apply_strb(win_low, w_data, w_strb);
            else if (aw_off == REG_HYST)
                hyst <= apply_strb(hyst, w_data, w_strb);
            else if (aw_off == REG_THR1)
                thr1 <= apply_strb(thr1, w_data, w_strb);
            else if (aw_off == REG_THR2)
                thr2 <= apply_strb(thr2, w_data, w_strb);
        end
    end

    // stage 1: pick channels and scale both
    logic [1:0] idx_a, idx_b;
    logic s1_vld, s1_red;
    logic signed [VAL_W-1:0] s1_a, s1_b;

    always_comb
    begin
        idx_a = cfg.chsel; // RL3
        idx_b = cfg.chsel;
        if (cfg.redundant)
        begin
            idx_a = {cfg.chsel[1], 1'b0}; // RL4
            idx_b = {cfg.chsel[1], 1'b1};
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s1_vld <= 1'b0;
            s1_red <= 1'b0;
            s1_a <= REG_RST;
            s1_b <= REG_RST;
        end
        else
        begin
            s1_vld <= i_sample_valid;
            if (i_sample_valid)
            begin
                s1_red <= cfg.redundant;
                s1_a <= aich_scale(i_samples.raw[idx_a], cfg.kind, scale_min, scale_max); // RL16
                if (cfg.diff)
                    s1_b <= aich_scale(i_samples.raw[idx_b], cfg.kind, scale2_min, scale2_max); // RL8
                else
                    s1_b <= aich_scale(i_samples.raw[idx_b], cfg.kind, scale_min, scale_max); // RL7
            end
        end
    end

    // stage 2: consolidate and check coherence
    logic signed [VAL_W:0] sum_ab, dif_ab;
    logic [VAL_W:0] gap_ab;
    logic signed [VAL_W-1:0] cons_val, value_q;
    logic val_vld, mismatch;
    assign sum_ab = aich_ext(s1_a) + aich_ext(s1_b);
    assign dif_ab = aich_ext(s1_a) - aich_ext(s1_b);
    assign gap_ab = dif_ab[VAL_W] ? unsigned'(-dif_ab) : unsigned'(dif_ab);

    always_comb
    begin
        cons_val = s1_a; // RL9
        if (s1_red)
        begin
            case (aich_cons_t'(cfg.cons))
                CONS_REDUNDANT: cons_val = s1_b; // RL9
                CONS_MAX: cons_val = (s1_a > s1_b) ? s1_a : s1_b; // RL10
                CONS_MIN: cons_val = (s1_a < s1_b) ? s1_a : s1_b; // RL11
                CONS_AVG: cons_val = VAL_W'(sum_ab >>> 1); // RL12
                default: cons_val = s1_a;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            val_vld <= 1'b0;
            value_q <= REG_RST;
            mismatch <= 1'b0;
        end
        else
        begin
            val_vld <= s1_vld;
            if (s1_vld)
            begin
                value_q <= cons_val; // RL13
                mismatch <= s1_red && (gap_ab > {1'b0, deviation}); // RL5
            end
            else if (!cfg.redundant)
                mismatch <= 1'b0;
        end
    end

    assign o_value = value_q; // RL13
    assign o_value_valid = val_vld;

    // coherence timeout, counted in whole seconds of continuous mismatch
    logic [31:0] tick_cnt, sec_cnt;
    logic incoh_clr;
    assign incoh_clr = do_write && aw_off == REG_STATUS && w_strb[0] && w_data[STAT_INCOH];

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tick_cnt <= REG_RST;
            sec_cnt <= REG_RST;
        end
        else if (!mismatch)
        begin
            tick_cnt <= REG_RST;
            sec_cnt <= REG_RST;
        end
        else if (tick_cnt == 32'(CYCLES_PER_SEC - 1))
        begin
            tick_cnt <= REG_RST;
            if (sec_cnt != 32'hffffffff)
                sec_cnt <= sec_cnt + 32'h1; // RL6
        end
        else
            tick_cnt <= tick_cnt + 32'h1;
    end

    // sticky; a new incoherence wins over a clear in the same cycle
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_incoherent <= 1'b0;
        else if (mismatch && sec_cnt >= timeout_s)
            o_incoherent <= 1'b1; // RL6
        else if (incoh_clr)
            o_incoherent <= 1'b0;
    end

    // stage 3: comparators on the consolidated value
    aich_win_t win_state, next_win;
    aich_thr_t t1_state, t2_state, next_t1, next_t2;
    logic signed [VAL_W:0] v_x, hi_m_h, lo_p_h;
    assign v_x = aich_ext(value_q); // RL23
    assign hi_m_h = aich_ext(win_high) - aich_ext(hyst);
    assign lo_p_h = aich_ext(win_low) + aich_ext(hyst);

    always_comb
    begin
        next_win = win_state;
        case (win_state)
            WIN_OUT:
                if (v_x < hi_m_h && v_x > aich_ext(win_low) && v_x >= lo_p_h)
                    next_win = WIN_IN; // RL20
                else
                    next_win = WIN_OUT; // RL19
            WIN_IN:
                if (v_x < aich_ext(win_high) && v_x > lo_p_h)
                    next_win = WIN_IN; // RL21
                else
                    next_win = WIN_OUT; // RL22
            default: next_win = WIN_OUT;
        endcase
    end

    always_comb
    begin
        next_t1 = t1_state;
        next_t2 = t2_state;
        if (t1_state == THR_UNDER && v_x > aich_ext(thr1))
            next_t1 = THR_OVER;
        else if (t1_state == THR_OVER && v_x < aich_ext(thr1) - aich_ext(hyst))
            next_t1 = THR_UNDER;
        if (t2_state == THR_UNDER && v_x > aich_ext(thr2))
            next_t2 = THR_OVER;
        else if (t2_state == THR_OVER && v_x < aich_ext(thr2) - aich_ext(hyst))
            next_t2 = THR_UNDER;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            win_state <= WIN_OUT;
            o_window_result_output <= 1'b0;
        end
        else if (!cfg.win_en)
        begin
            win_state <= WIN_OUT;
            o_window_result_output <= 1'b0; // RL17
        end
        else if (val_vld)
        begin
            win_state <= next_win;
            o_window_result_output <= (next_win == WIN_IN); // RL18
        end
    end

    // simple thresholds run only while the window comparator is off
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            t1_state <= THR_UNDER;
            t2_state <= THR_UNDER;
            o_thr1 <= 1'b0;
            o_thr2 <= 1'b0;
        end
        else
        begin
            if (cfg.win_en || !cfg.thr1_en)
            begin
                t1_state <= THR_UNDER; // RL2
                o_thr1 <= 1'b0;
            end
            else if (val_vld)
            begin
                t1_state <= next_t1;
                o_thr1 <= (next_t1 == THR_OVER);
            end
            if (cfg.win_en || !cfg.thr2_en)
            begin
                t2_state <= THR_UNDER; // RL2
                o_thr2 <= 1'b0;
            end
            else if (val_vld)
            begin
                t2_state <= next_t2;
                o_thr2 <= (next_t2 == THR_OVER);
            end
        end
    end

    // read channel
    logic [31:0] rd_word;
    logic [1:0] rd_resp;
    logic [7:0] ar_off;
    assign ar_off = {i_araddr[7:2], 2'b00};

    always_comb
    begin
        rd_word = REG_RST;
        rd_resp = RESP_OKAY;
        if (ar_off == REG_CTRL)
            rd_word = ctrl;
        else if (ar_off == REG_SCALE_MIN)
            rd_word = scale_min;
        else if (ar_off == REG_SCALE_MAX)
            rd_word = scale_max;
        else if (ar_off == REG_SCALE2_MIN)
            rd_word = scale2_min;
        else if (ar_off == REG_SCALE2_MAX)
            rd_word = scale2_max;
        else if (ar_off == REG_DEVIATION)
            rd_word = deviation;
        else if (ar_off == REG_TIMEOUT)
            rd_word = timeout_s;
        else if (ar_off == REG_WIN_HIGH)
            rd_word = win_high;
        else if (ar_off == REG_WIN_LOW)
            rd_word = win_low;
        else if (ar_off == REG_HYST)
            rd_word = hyst;
        else if (ar_off == REG_THR1)
            rd_word = thr1;
        else if (ar_off == REG_THR2)
            rd_word = thr2;
        else if (ar_off == REG_STATUS)
        begin
            rd_word[STAT_INCOH] = o_incoherent;
            rd_word[STAT_MISMATCH] = mismatch;
            rd_word[STAT_WIN] = o_window_result_output;
            rd_word[STAT_THR1] = o_thr1;
            rd_word[STAT_THR2] = o_thr2;
        end
        else if (ar_off == REG_VALUE)
            rd_word = value_q;
        else
            rd_resp = RESP_SLVERR;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= REG_RST;
            o_rresp <= RESP_OKAY;
        end
        else if (i_arvalid && o_arready)
        begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_word;
            o_rresp <= rd_resp;
        end
        else if (o_rvalid && i_rready)
        begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    sequence sample_in_s;
        i_sample_valid && !cfg.redundant && !$changed(ctrl);
    endsequence

    single_chan_pick_a: assert property (sample_in_s |=> s1_a == aich_scale( // RL3
        $past(i_samples.raw[cfg.chsel]), $past(cfg.kind), $past(scale_min), $past(scale_max)))
        else $error("single mode scaled the wrong channel");
    equal_scale_a: assert property (i_sample_valid && cfg.redundant && !cfg.diff // RL7
        |=> s1_b == aich_scale($past(i_samples.raw[{cfg.chsel[1], 1'b1}]),
            $past(cfg.kind), $past(scale_min), $past(scale_max)))
        else $error("equal sensors not scaled alike");
    cons_max_val_a: assert property (s1_vld && s1_red && cfg.cons == CONS_MAX // RL10
        |=> value_q >= $past(s1_a) && value_q >= $past(s1_b))
        else $error("max consolidation below an input");
    cons_min_val_a: assert property (s1_vld && s1_red && cfg.cons == CONS_MIN // RL11
        |=> value_q <= $past(s1_a) && value_q <= $past(s1_b))
        else $error("min consolidation above an input");
    cons_avg_val_a: assert property (s1_vld && s1_red && cfg.cons == CONS_AVG // RL12
        |=> value_q == VAL_W'((aich_ext($past(s1_a)) + aich_ext($past(s1_b))) >>> 1))
        else $error("average consolidation wrong");
    cons_prim_val_a: assert property (s1_vld && cfg.cons == CONS_PRIMARY // RL9
        |=> value_q == $past(s1_a))
        else $error("primary consolidation wrong");
    win_out_hold_a: assert property (val_vld && cfg.win_en && win_state == WIN_OUT // RL19
        && v_x >= hi_m_h ##1 cfg.win_en |-> win_state == WIN_OUT && !o_window_result_output)
        else $error("window left out state near high edge");
    win_in_exit_a: assert property (val_vld && cfg.win_en && win_state == WIN_IN // RL22
        && v_x >= aich_ext(win_high) |=> !o_window_result_output)
        else $error("window stayed in at high threshold");
    win_off_zero_a: assert property (!cfg.win_en [*2] |-> !o_window_result_output) // RL17
        else $error("window output set while disabled");
    thr_gate_a: assert property (cfg.win_en [*2] |-> !o_thr1 && !o_thr2) // RL2
        else $error("threshold active with window comparator");
    coherent_clr_a: assert property (!mismatch |=> sec_cnt == 32'h0 && tick_cnt == 32'h0) // RL6
        else $error("timeout counter kept running while coherent");
    incoh_set_a: assert property (mismatch && sec_cnt >= timeout_s |=> o_incoherent) // RL6
        else $error("incoherence not flagged after timeout");
    rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid ##0 !o_arready)
        else $error("read answer not one cycle after address");

endmodule : aich_channel

/* aich_sensor_model.sv */
`timescale 1ns/1ps
module aich_sensor_model
    import aich_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_go,
    input wire aich_samples_t i_codes,
    output logic o_sample_valid,
    output aich_samples_t o_samples
);
    // codes are only valid in the strobe cycle; inverted after it to expose late use
    always_ff @(posedge i_clk)
    begin
        o_sample_valid <= i_go;
        o_samples <= i_go ? i_codes : ~i_codes;
    end
endmodule : aich_sensor_model

/* testbench.sv */
`timescale 1ns/1ps
module testbench
    import aich_pkg::*;
;
    logic i_clk = 0, i_rst = 1, go = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdata;
    logic [1:0] rresp, bresp;
    logic sv, vv, win, t1, t2, inc, awr, wrd, bv, arr, rv;
    logic signed [31:0] val;
    aich_samples_t codes = '0, smp;
    int err_count = 0, cmp_count = 0, cyc = 0;
    aich_sensor_model i_sens (.i_clk(i_clk), .i_go(go), .i_codes(codes),
        .o_sample_valid(sv), .o_samples(smp));
    aich_channel #(.CYCLES_PER_SEC(10)) i_dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_sample_valid(sv), .i_samples(smp), .o_value_valid(vv), .o_value(val),
        .o_window_result_output(win), .o_thr1(t1), .o_thr2(t2), .o_incoherent(inc),
        .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf),
        .i_wvalid(wv), .o_wready(wrd), .o_bresp(bresp), .o_bvalid(bv), .i_bready(bry),
        .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rv), .i_rready(rry));
    initial
    begin
        forever #5 i_clk = ~i_clk;
    end
    task automatic end_of_test();
        $display("mismatches %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s exp %0h got %0h", n, e, g);
        end
    endtask : chk
    // scaling truncates its reciprocal, so one count low is accepted
    task automatic chkv(input string n, input int e);
        cmp_count++;
        if (val !== 32'(e) && val !== 32'(e - 1))
        begin
            err_count++;
            $display("BAD %s exp %0d got %0d", n, e, val);
        end
    endtask : chkv
    function automatic int ev(int k, int raw, int lo, int hi);
        int f;
        f = (k == 0) ? int'(RAW_LIVE_ZERO) : 0;
        return int'(lo + longint'(raw - f) * (hi - lo) / (int'(RAW_FULL) - f));
    endfunction : ev
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do
        begin
            @(posedge i_clk);
            if (awr)
                awv <= 1'b0;
            if (wrd)
                wv <= 1'b0;
        end while (bv !== 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do
        begin
            @(posedge i_clk);
            if (arr)
                arv <= 1'b0;
        end while (rv !== 1'b1);
    endtask : rd
    // primary codes land on channels 1 and 3, second codes on channels 2 and 4
    task automatic put(input logic [15:0] a, input logic [15:0] b);
        codes <= {b, a, b, a};
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk("vvalid", 1, vv);
        @(posedge i_clk);
        chk("vpulse", 0, vv);
        repeat (2) @(posedge i_clk);
    endtask : put
    task automatic t_scale();
        wr(REG_SCALE_MIN, -32'sh64);
        wr(REG_SCALE_MAX, 32'h384);
        for (int k = 0; k < 4; k++)
        begin
            wr(REG_CTRL, 32'(k) | 32'h8);
            put(16'h1111, 16'h7d00);
            chkv("scaled", ev(k, 32000, -100, 900));
            put(16'h7d00, RAW_FULL);
            chkv("full", 900);
            put(16'hffff, (k == 0) ? RAW_LIVE_ZERO : 16'h0);
            chkv("floor", -100);
        end
        rd(REG_SCALE_MAX);
        chk("rdback", 32'h384, rdata);
        rd(8'h40);
        chk("resp", 32'(RESP_SLVERR), 32'(rresp));
        wr(8'h40, 32'h0);
        chk("bresp", 32'(RESP_SLVERR), 32'(bresp));
    endtask : t_scale
    task automatic t_cons();
        int a;
        int b;
        int e[6];
        wr(REG_SCALE_MIN, 32'h0);
        wr(REG_SCALE_MAX, 32'hfa00);
        wr(REG_DEVIATION, 32'hffff);
        for (int s = 0; s < 2; s++)
            for (int c = 0; c < 6; c++)
            begin
                a = s ? 1000 : 3000;
                b = 4000 - a;
                e = '{a, b, 3000, 1000, 2000, a};
                wr(REG_CTRL, 32'h15 | 32'(c) << 6);
                put(16'(a), 16'(b));
                chkv("cons", e[c]);
            end
    endtask : t_cons
    task automatic t_coh();
        wr(REG_DEVIATION, 32'h8);
        wr(REG_SCALE2_MAX, 32'h7d00);
        wr(REG_CTRL, 32'h75);
        wr(REG_STATUS, 32'h1);
        put(16'h3e8, 16'h7d0);
        chkv("rescaled", 1000);
        chk("coherent", 0, inc);
        wr(REG_CTRL, 32'h55);
        put(16'h3e8, 16'h7d0);
        chk("incoh", 1, inc);
        wr(REG_TIMEOUT, 32'h1);
        put(16'h3e8, 16'h3e8);
        wr(REG_STATUS, 32'h1);
        chk("cleared", 0, inc);
        put(16'h3e8, 16'h7d0);
        chk("early", 0, inc);
        repeat (12) @(posedge i_clk);
        chk("late", 1, inc);
        rd(REG_STATUS);
        chk("status", 32'h3, rdata);
    endtask : t_coh
    task automatic t_win();
        int cw[7] = '{2900, 1100, 2000, 2900, 3100, 2000, 900};
        logic [6:0] ew = 7'h2c;
        wr(REG_WIN_HIGH, 32'hbb8);
        wr(REG_WIN_LOW, 32'h3e8);
        wr(REG_HYST, 32'hc8);
        wr(REG_THR1, 32'h1f4);
        wr(REG_CTRL, 32'h601);
        chk("start", 0, win);
        for (int i = 0; i < 7; i++)
        begin
            put(16'(cw[i]), 16'h0);
            chk("window", ew[i], win);
            chk("thr_off", 0, t1);
        end
        wr(REG_THR2, 32'h3e8);
        wr(REG_CTRL, 32'hc01);
        put(16'h7d0, 16'h0);
        chk("thr_on", 1, t1);
        chk("thr2_on", 1, t2);
        chk("win_off", 0, win);
    endtask : t_win
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_scale();
        t_cons();
        t_coh();
        t_win();
        end_of_test();
    end
endmodule : testbench
